// file: hw/step_seq_pkg.sv
// Constants and state type of the event step sequencer
package step_seq_pkg;
    localparam int        STEPS        = 16;        // Steps per sequence
    localparam int        OUT_W        = 16;        // Output pattern width
    localparam int        CNT_W        = 16;        // Status counter width
    localparam int        STEP_W       = 5;         // Step number width, 1..16
    localparam int        EVSEL_W      = 5;         // Event select, 0 = none
    localparam int        POOL_W       = 6;         // Counter pool index, 64 counters
    localparam int        PRE_W        = 22;        // Hundredth prescaler width
    // Timing
    localparam int        CLK_NS       = 4;         // Clock period
    localparam int        HUNDREDTH_NS = 10000000;  // 0.01 s base tick
    localparam int        HUND_CYC     = HUNDREDTH_NS / CLK_NS;
    // Word indices of the register map (byte address = 4 * index)
    localparam bit [7:0]  W_CONFIG     = 8'h00;     // [0] retentive
    localparam bit [7:0]  W_STATUS     = 8'h01;     // [0] done, [1] running
    localparam bit [7:0]  W_TBASE      = 8'h02;     // Timebase in hundredths
    localparam bit [7:0]  W_LAST       = 8'h03;     // Final step number
    localparam bit [7:0]  W_CBASE      = 8'h04;     // First counter of four
    localparam bit [7:0]  W_CFGPRE     = 8'h05;     // Configured preset step
    localparam bit [1:0]  R_POOL       = 2'h1;      // Words 0x40..0x7f, counter pool
    localparam bit [3:0]  R_TICKS      = 4'h8;      // Words 0x80..0x8f, tick counts
    localparam bit [3:0]  R_PAT        = 4'h9;      // Words 0x90..0x9f, patterns
    localparam bit [3:0]  R_EVSEL      = 4'ha;      // Words 0xa0..0xaf, event selects
    localparam int        DONE_BIT     = 31;        // Done flag in first counter word
    // Reset values
    localparam bit        RST_RETENT   = 1'b1;
    localparam bit [15:0] RST_TBASE    = 16'h0001;
    localparam bit [4:0]  RST_LAST     = 5'h10;
    localparam bit [4:0]  RST_STEP     = 5'h01;
    localparam bit [5:0]  RST_CBASE    = 6'h00;

    // Whole state of the sequencer
    typedef struct packed {
        logic                             ack;      // Bus answer cycle
        logic [31:0]                      rdata;    // Captured read data
        logic                             jog_prev; // Jog edge detect
        logic                             run_prev; // Run entry detect
        logic [PRE_W-1:0]                 pre;      // Hundredth prescaler
        logic                             pend;     // Hundredth waiting for scan
        logic                             done;     // Sequence done flag
        logic [CNT_W-1:0]                 count;    // Count in step
        logic [CNT_W-1:0]                 timer;    // Base tick timer
        logic [STEP_W-1:0]                preset;   // Preset step counter
        logic [STEP_W-1:0]                cur;      // Current step counter
        logic                             retent;   // Retentive configuration
        logic [CNT_W-1:0]                 tbase;    // Timebase
        logic [STEP_W-1:0]                last;     // Final step
        logic [POOL_W-1:0]                cbase;    // First counter number
        logic [STEP_W-1:0]                cfgpre;   // Configured preset
        logic [STEPS-1:0][CNT_W-1:0]      ticks;    // Per-step tick counts
        logic [STEPS-1:0][OUT_W-1:0]      pat;      // Per-step patterns
        logic [STEPS-1:0][EVSEL_W-1:0]    evsel;    // Per-step event selects
        logic [OUT_W-1:0]                 out;      // Output pins
    } state_t;
endpackage

// file: hw/event_step_sequencer.sv
// Event step sequencer with Avalon-MM register slave
// Summary of operation
// - base timer counts hundredths of a second
// - preset step changes only by write/reinit
// - done flag sets at finish, clears at reset
// - any step may be the final step
// - final step done sets flag, enters completion
// - completed holds final pattern and step
// - completed ignores start and jog
// - leave completion on reset/run entry, preset
// - start runs timer and watches events
// - start off freezes step, timer, counts
// - jog rising edge advances one step
// - reset beats start, holds preset step
// - preset step 1..16, entered on reset/non-retentive run entry
// - optional per-step tick count
// - counter number picks four of 64
// - optional per-step event input
// - outputs follow step whenever in run
// - non-retentive run entry reinitialises counters
// - retentive is the default
// - jog while running clears timer, continues
// - jog at final step enters completion
// - count reaching tick count advances step
// - timer advances only while event true
// - step time is hundredth*timebase*ticks
`timescale 1ns/100ps
module event_step_sequencer
    import step_seq_pkg::*;
#(
    parameter int HUND_CYCLES = HUND_CYC           // Clocks per hundredth
) (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        SRST,
    // Avalon-MM slave
    input  wire logic [9:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    // Controls from the ladder program
    input  wire logic        RUN_MODE,
    input  wire logic        SCAN_TICK,
    input  wire logic        DRUM_START,
    input  wire logic        DRUM_JOG,
    input  wire logic        DRUM_RESET,
    input  wire logic [15:0] EVENT_IN,
    // Sequencer outputs
    output logic      [15:0] STEP_OUT,
    output logic             SEQ_DONE
);
    state_t s_q;                         // Registered state
    state_t s_d;                         // Next state

    logic       req;                     // Bus request present
    logic       wr_go;                   // Write takes effect now
    logic [7:0] widx;                    // Word index
    logic [3:0] cidx;                    // Current step table index
    logic       ev_ok;                   // Current step event condition
    logic       jog_rise;                // Jog off-to-on
    logic       run_entry;               // Run mode entered

    assign req      = AVS_READ | AVS_WRITE;
    assign wr_go    = AVS_WRITE & s_q.ack;
    assign widx     = AVS_ADDRESS[9:2];
    assign cidx     = 4'(s_q.cur - 5'd1);
    assign jog_rise = DRUM_JOG & ~s_q.jog_prev;
    assign run_entry = RUN_MODE & ~s_q.run_prev;

    // One wait state per access, answer from flops
    assign AVS_WAITREQUEST = req & ~s_q.ack;
    assign AVS_READDATA    = s_q.rdata;
    assign STEP_OUT        = s_q.out;
    assign SEQ_DONE        = s_q.done;

    // Unassigned event means timing alone decides
    always_comb begin
        if (s_q.evsel[cidx] == '0 || s_q.evsel[cidx] > 5'd16) begin
            ev_ok = 1'b1;
        end else begin
            ev_ok = EVENT_IN[4'(s_q.evsel[cidx] - 5'd1)];
        end
    end

    // Byte-lane merge of a write
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Legal step number check, 1..16
    function automatic logic step_ok(input logic [31:0] v);
        return (v >= 32'd1) && (v <= 32'd16);
    endfunction

    // Next state
    always_comb begin
        logic [31:0]    rd;              // Read mux
        logic [31:0]    wv;              // Merged write value
        logic [6:0]     rel;             // Pool offset from counter base
        logic [CNT_W-1:0] t1;            // Timer plus one
        logic [CNT_W-1:0] c1;            // Count plus one
        logic           adv;             // Step advance request
        rd  = '0;
        wv  = '0;
        rel = {1'b0, widx[5:0]} - {1'b0, s_q.cbase};
        t1  = s_q.timer + 16'd1;
        c1  = s_q.count + 16'd1;
        adv = 1'b0;
        s_d = s_q;
        s_d.ack      = req & ~s_q.ack;
        s_d.jog_prev = DRUM_JOG;
        s_d.run_prev = RUN_MODE;

        // Hundredth prescaler, pending until the next scan
        if (s_q.pre >= PRE_W'(HUND_CYCLES - 1)) begin
            s_d.pre  = '0;
            s_d.pend = 1'b1;
        end else begin
            s_d.pre = s_q.pre + 1'b1;
        end

        if (run_entry) begin
            // Run entry leaves completion; goes to preset unless retentive and not done
            s_d.done = 1'b0;
            if (!s_q.retent) begin
                s_d.count  = '0;
                s_d.timer  = '0;
                s_d.preset = s_q.cfgpre;
                s_d.cur    = s_q.cfgpre;
            end else if (s_q.done) begin
                s_d.cur = s_q.preset;
            end
        end else if (RUN_MODE) begin
            if (DRUM_RESET) begin
                // Reset outranks start and jog and is held
                s_d.cur   = s_q.preset;
                s_d.done  = 1'b0;
                s_d.timer = '0;
                s_d.count = '0;
            end else if (s_q.done) begin
                // Completed: start and jog have no effect
                s_d.cur = s_q.cur;
            end else if (jog_rise) begin
                // Jog steps regardless of start
                adv = 1'b1;
            end else if (DRUM_START && SCAN_TICK) begin
                // One evaluation per scan
                if (s_q.ticks[cidx] == '0) begin
                    // Event-only step
                    adv = (s_q.evsel[cidx] != '0) & ev_ok;
                end else if (ev_ok && s_q.pend) begin
                    // Consume one hundredth; one landing this cycle is kept
                    s_d.pend = (s_q.pre >= PRE_W'(HUND_CYCLES - 1));
                    if (t1 >= s_q.tbase) begin
                        s_d.timer = '0;
                        s_d.count = c1;
                        adv = (c1 >= s_q.ticks[cidx]);
                    end else begin
                        s_d.timer = t1;
                    end
                end
            end
            // Start off: only reset and jog above move the counters
        end

        // Step advance, final step ends the sequence
        if (adv) begin
            s_d.timer = '0;
            s_d.count = '0;
            if (s_q.cur >= s_q.last) begin
                s_d.done = 1'b1;
            end else begin
                s_d.cur = s_q.cur + 5'd1;
            end
        end

        // Register reads, captured in the wait cycle
        if (widx[7:6] == R_POOL) begin
            unique case (rel)
                7'd0: begin
                    rd = {s_q.done, 15'h0000, s_q.count};
                end
                7'd1: begin
                    rd = {16'h0000, s_q.timer};
                end
                7'd2: begin
                    rd = {27'h0000000, s_q.preset};
                end
                7'd3: begin
                    rd = {27'h0000000, s_q.cur};
                end
                default: begin
                    rd = '0;             // Counters of other users
                end
            endcase
        end else if (widx[7:4] == R_TICKS) begin
            rd = {16'h0000, s_q.ticks[widx[3:0]]};
        end else if (widx[7:4] == R_PAT) begin
            rd = {16'h0000, s_q.pat[widx[3:0]]};
        end else if (widx[7:4] == R_EVSEL) begin
            rd = {27'h0000000, s_q.evsel[widx[3:0]]};
        end else begin
            unique case (widx)
                W_CONFIG: begin
                    rd = {31'h00000000, s_q.retent};
                end
                W_STATUS: begin
                    rd = {30'h00000000, RUN_MODE & DRUM_START & ~DRUM_RESET, s_q.done};
                end
                W_TBASE: begin
                    rd = {16'h0000, s_q.tbase};
                end
                W_LAST: begin
                    rd = {27'h0000000, s_q.last};
                end
                W_CBASE: begin
                    rd = {26'h0000000, s_q.cbase};
                end
                W_CFGPRE: begin
                    rd = {27'h0000000, s_q.cfgpre};
                end
                default: begin
                    rd = '0;             // Unmapped reads as zero
                end
            endcase
        end
        if (AVS_READ && !s_q.ack) begin
            s_d.rdata = rd;
        end

        // Register writes on the answer edge, bus last
        wv = be_merge(rd, AVS_WRITEDATA, AVS_BYTEENABLE);
        if (wr_go) begin
            if (widx[7:6] == R_POOL) begin
                if (rel == 7'd2 && step_ok(wv)) begin
                    s_d.preset = wv[4:0];
                end
            end else if (widx[7:4] == R_TICKS) begin
                s_d.ticks[widx[3:0]] = wv[15:0];
            end else if (widx[7:4] == R_PAT) begin
                s_d.pat[widx[3:0]] = wv[15:0];
            end else if (widx[7:4] == R_EVSEL) begin
                s_d.evsel[widx[3:0]] = wv[4:0];
            end else if (widx == W_CONFIG) begin
                s_d.retent = wv[0];
            end else if (widx == W_TBASE) begin
                s_d.tbase = wv[15:0];
            end else if (widx == W_LAST && step_ok(wv)) begin
                s_d.last = wv[4:0];
            end else if (widx == W_CBASE && wv <= 32'd60) begin
                s_d.cbase = wv[5:0];
            end else if (widx == W_CFGPRE && step_ok(wv)) begin
                s_d.cfgpre = wv[4:0];
            end
        end

        // Outputs track the step whenever in run mode
        if (RUN_MODE) begin
            s_d.out = s_d.pat[4'(s_d.cur - 5'd1)];
        end else begin
            s_d.out = '0;
        end
    end

    // State register; power-up acts as a non-retentive start
    always_ff @(posedge CLK) begin
        if (SRST) begin
            s_q        <= '0;
            s_q.retent <= RST_RETENT;
            s_q.tbase  <= RST_TBASE;
            s_q.last   <= RST_LAST;
            s_q.cbase  <= RST_CBASE;
            s_q.cfgpre <= RST_STEP;
            s_q.preset <= RST_STEP;
            s_q.cur    <= RST_STEP;
        end else begin
            s_q <= s_d;
        end
    end

    // Reset holds the preset step and clears done
    property p_reset_preset;
        @(posedge CLK) disable iff (SRST)
        (RUN_MODE && s_q.run_prev && DRUM_RESET && !wr_go) |=>
            (s_q.cur == $past(s_q.preset)) && !SEQ_DONE && (s_q.timer == '0);
    endproperty
    a_reset_preset: assert property (p_reset_preset) else $error("reset did not hold preset");

    // Completed state holds step and flag
    property p_done_hold;
        @(posedge CLK) disable iff (SRST)
        (SEQ_DONE && RUN_MODE && s_q.run_prev && !DRUM_RESET) |=>
            SEQ_DONE && $stable(s_q.cur) && $stable(s_q.count);
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("completed state moved");

    // Start off freezes the sequencer
    property p_freeze;
        @(posedge CLK) disable iff (SRST)
        (RUN_MODE && s_q.run_prev && !DRUM_START && !DRUM_RESET && !jog_rise && !wr_go) |=>
            $stable(s_q.cur) && $stable(s_q.timer) && $stable(s_q.count) && $stable(STEP_OUT);
    endproperty
    a_freeze: assert property (p_freeze) else $error("frozen sequencer moved");

    // Jog below the final step moves one step and clears the timer
    property p_jog;
        @(posedge CLK) disable iff (SRST)
        (RUN_MODE && s_q.run_prev && jog_rise && !DRUM_RESET && !SEQ_DONE
         && s_q.cur < s_q.last && !wr_go) |=>
            (s_q.cur == $past(s_q.cur) + 5'd1) && (s_q.timer == '0) && (s_q.count == '0);
    endproperty
    a_jog: assert property (p_jog) else $error("jog did not advance one step");

    // Jog at the final step completes
    property p_jog_last;
        @(posedge CLK) disable iff (SRST)
        (RUN_MODE && s_q.run_prev && jog_rise && !DRUM_RESET && !SEQ_DONE && s_q.cur == s_q.last)
            |=> SEQ_DONE ##1 (SEQ_DONE || DRUM_RESET || !RUN_MODE || $past(DRUM_RESET));
    endproperty
    a_jog_last: assert property (p_jog_last) else $error("jog at final step did not complete");

    // Timer stands while the event is false
    property p_timer_gate;
        @(posedge CLK) disable iff (SRST)
        (RUN_MODE && s_q.run_prev && !ev_ok && !DRUM_RESET && !jog_rise && !wr_go) |=>
            $stable(s_q.timer) && $stable(s_q.cur);
    endproperty
    a_timer_gate: assert property (p_timer_gate) else $error("timer ran without event");

    // Outputs show the current step pattern in run mode
    property p_out_follow;
        @(posedge CLK) disable iff (SRST)
        (RUN_MODE && s_q.run_prev) |=> !$past(RUN_MODE) || (STEP_OUT == s_q.pat[cidx]);
    endproperty
    a_out_follow: assert property (p_out_follow) else $error("outputs differ from step pattern");

    // Retentive run entry keeps the counters
    property p_retent;
        @(posedge CLK) disable iff (SRST)
        (run_entry && s_q.retent && !SEQ_DONE && !wr_go) |=>
            $stable(s_q.cur) && $stable(s_q.count) && $stable(s_q.timer) && $stable(s_q.preset);
    endproperty
    a_retent: assert property (p_retent) else $error("retentive entry changed counters");

    // Non-retentive run entry reinitialises
    property p_nonretent;
        @(posedge CLK) disable iff (SRST)
        (run_entry && !s_q.retent && !wr_go) |=>
            (s_q.count == '0) && (s_q.timer == '0) && (s_q.cur == $past(s_q.cfgpre)) && !SEQ_DONE;
    endproperty
    a_nonretent: assert property (p_nonretent) else $error("non-retentive entry not initialised");

    // Done falls only on the reset control or run entry
    property p_done_clear;
        @(posedge CLK) disable iff (SRST)
        (SEQ_DONE && !DRUM_RESET && !run_entry) |=> SEQ_DONE;
    endproperty
    a_done_clear: assert property (p_done_clear) else $error("done flag dropped without reset");

    // Out of run mode the outputs are off
    property p_out_idle;
        @(posedge CLK) disable iff (SRST)
        !RUN_MODE |=> (STEP_OUT == '0);
    endproperty
    a_out_idle: assert property (p_out_idle) else $error("outputs on out of run mode");
endmodule // event_step_sequencer

// file: sim/ladder_scan.sv
// Scan pacing model of the ladder program driving the sequencer
`timescale 1ns/100ps
module ladder_scan #(
    parameter int PERIOD = 16              // Clocks per controller scan
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Scan pulse and running count of pulses
    output logic      tick,
    output int        n
);
    int c;                                 // Position within the scan

    // One-cycle pulse per scan, period longer than the hundredth so one is always pending
    always_ff @(posedge clk) begin
        if (srst) begin
            c    <= 0;
            tick <= 1'b0;
            n    <= 0;
        end else begin
            tick <= (c == PERIOD - 1);
            c    <= (c == PERIOD - 1) ? 0 : c + 1;
            if (c == PERIOD - 1) begin
                n <= n + 1;
            end
        end
    end
endmodule // ladder_scan

// file: sim/testbench.sv
// Self-checking bench for the event step sequencer
`timescale 1ns/100ps
module testbench;
    import step_seq_pkg::*;
    logic        clk = 0, srst = 1, rd = 0, wr = 0, run = 0, start = 0, jog = 0, rst = 0;
    logic [9:0]  addr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [15:0] ev = '0, sout;
    logic        waitreq, done, tick;
    int          n_scan, t, n_mismatch = 0, check_count = 0, seed = 32'h486f;
    logic [15:0] pat [1:3];                // Random patterns of the used steps
    logic [31:0] expq [$];                 // Expected read data, oldest first

    // Short hundredth so step times stay a few hundred clocks
    event_step_sequencer #(.HUND_CYCLES(8)) i_event_step_sequencer (
        .CLK(clk), .SRST(srst), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(waitreq), .RUN_MODE(run), .SCAN_TICK(tick), .DRUM_START(start),
        .DRUM_JOG(jog), .DRUM_RESET(rst), .EVENT_IN(ev), .STEP_OUT(sout), .SEQ_DONE(done));
    ladder_scan i_ladder_scan (.clk(clk), .srst(srst), .tick(tick), .n(n_scan));

    // 250 MHz clock
    initial begin
        forever #2 clk = ~clk;
    end

    // Hang guard, well above the expected run length
    initial begin
        #100000;
        n_mismatch++;
        wrap_up();
    end

    // Read answers compared against the oldest note
    always @(posedge clk) begin
        if (rd && waitreq === 1'b0) begin
            chk("readdata", rdata, expq[0]);
            void'(expq.pop_front());
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask

    // One Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wr    <= w;
        rd    <= !w;
        wdata <= d;
        @(posedge clk);
        // Only the watchdog ends a wait for the answer
        while (waitreq !== 1'b0) begin
            @(posedge clk);
        end
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic rdx(input logic [9:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    // Bounded wait for a pattern on the outputs
    task automatic waitv(input logic [15:0] v);
        int g;
        g = 0;
        while (sout !== v && g < 400) begin
            @(posedge clk);
            g++;
        end
        chk("step_out", {16'h0, sout}, {16'h0, v});
    endtask

    // Let k scans pass and be consumed
    task automatic scans(input int k);
        int e;
        e = n_scan + k;
        while (n_scan < e) @(posedge clk);
        repeat (2) @(posedge clk);
    endtask

    task automatic pulse_jog;
        @(posedge clk) jog <= 1'b1;
        @(posedge clk) jog <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rdx(10'h000, 32'h1);
        rdx(10'h10c, 32'h1);
        rdx(10'h040, 32'h0);
        for (int i = 1; i <= 3; i++) begin
            pat[i] = {14'($random(seed)), 2'(i)};
            bus(1'b1, 10'h240 + 10'(4 * (i - 1)), {16'h0, pat[i]});
        end
        // Step 1 timed only, step 2 event only, step 3 final with neither, ended by jog
        bus(1'b1, 10'h200, 32'h2);
        bus(1'b1, 10'h284, 32'h1);
        bus(1'b1, 10'h008, 32'h3);
        bus(1'b1, 10'h00c, 32'h3);
        bus(1'b1, 10'h00c, 32'h11);
        rdx(10'h00c, 32'h3);
        @(posedge clk) run <= 1'b1;
        waitv(pat[1]);
        start <= 1'b1;
        scans(5);
        start <= 1'b0;
        rdx(10'h100, 32'h1);
        rdx(10'h104, 32'h2);
        repeat (40) @(posedge clk);
        rdx(10'h104, 32'h2);
        chk("step_out", {16'h0, sout}, {16'h0, pat[1]});
        t = n_scan;
        start <= 1'b1;
        waitv(pat[2]);
        chk("scans", n_scan - t, 32'h1);
        scans(3);
        chk("step_out", {16'h0, sout}, {16'h0, pat[2]});
        ev <= 16'h0001;
        waitv(pat[3]);
        ev <= 16'h0000;
        pulse_jog();
        chk("done", {31'h0, done}, 32'h1);
        waitv(pat[3]);
        rdx(10'h100, 32'h80000000);
        rdx(10'h004, 32'h3);
        pulse_jog();
        rdx(10'h10c, 32'h3);
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        chk("done", {31'h0, done}, 32'h0);
        waitv(pat[1]);
        scans(3);
        chk("step_out", {16'h0, sout}, {16'h0, pat[1]});
        rdx(10'h10c, 32'h1);
        rst <= 1'b0;
        scans(2);
        pulse_jog();
        waitv(pat[2]);
        rdx(10'h104, 32'h0);
        start <= 1'b0;
        pulse_jog();
        waitv(pat[3]);
        bus(1'b1, 10'h108, 32'h2);
        rdx(10'h108, 32'h2);
        @(posedge clk) rst <= 1'b1;
        waitv(pat[2]);
        rst <= 1'b0;
        // Non-retentive run entry reloads the configured preset
        bus(1'b1, 10'h000, 32'h0);
        @(posedge clk) run <= 1'b0;
        waitv(16'h0000);
        run <= 1'b1;
        waitv(pat[1]);
        rdx(10'h108, 32'h1);
        rdx(10'h100, 32'h0);
        bus(1'b1, 10'h010, 32'h4);
        rdx(10'h11c, 32'h1);
        rdx(10'h10c, 32'h0);
        wrap_up();
    end
endmodule // testbench
